/* logic/cmob_access.sv */
// Purpose: identifier tag, mask, time stamp and data storage of the message objects
// Assumes: engine ports on aclk; software over AXI4-Lite
// Notes:   object storage has no reset value; page and bus state do
// What this block does
// R1: Remote tag sent, overwritten on reception
// R2: Auto reply clears remote tag before sending
// R3: Extended identifier at tag 31:3
// R4: Reserved bit 0 sent, bit 1 sent only in extended layout; both replaced
// R5: Software writes zero to standard tag bit 1
// R6: Standard bit 1 excluded from comparison
// R7: Identifier mask bit enables or forces compare
// R8: Remote mask bit enables or forces compare
// R9: Extension mask bit enables or forces compare
// R10: Software zeroes standard mask bits 20:3
// R11: Software should zero extended mask bit 1
// R12: Read-only 16-bit stamp, low/high bytes
// R13: Data window reaches byte at index
// R14: Page write selects byte immediately
// R15: Data access steps index when enabled
// R16: Index wraps modulo eight
// R17: Autostep control active low
// R18: Page holds object, autostep, index
// R19: Match needs all enabled bits equal
// R20: Storage per object, reached through page
`timescale 1ns/1ps
`include "cmob_defines.svh"
module cmob_access (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [5:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [5:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire cmob_pkg::cmob_obj_t  tx_obj,
  input  wire cmob_pkg::cmob_idx_t  tx_index,
  output cmob_pkg::cmob_tx_t        tx_out,
  input  wire logic                 reply_clear,
  input  wire cmob_pkg::cmob_obj_t  reply_obj,
  input  wire logic                 rx_store,
  input  wire cmob_pkg::cmob_obj_t  rx_obj,
  input  wire cmob_pkg::cmob_frame_t rx_frame,
  input  wire logic [15:0]          rx_stamp,
  input  wire logic                 rx_data_we,
  input  wire cmob_pkg::cmob_idx_t  rx_data_index,
  input  wire logic [7:0]           rx_data_byte,
  input  wire cmob_pkg::cmob_frame_t accept_frame,
  output logic [`CMOB_NUM_OBJ-1:0]  accept_match
);
  import cmob_pkg::*;

  localparam int NOBJ = `CMOB_NUM_OBJ;

  // Per-object storage
  logic [31:0] tag    [NOBJ]; // R20
  logic [31:0] mask   [NOBJ];
  logic [15:0] stamp  [NOBJ];
  logic [7:0]  data   [NOBJ][8];
  logic        layout [NOBJ];

  // Page selection
  cmob_obj_t   object_number;
  logic        index_autostep_disable;
  cmob_idx_t   data_buffer_index;

  // Bus holding registers
  logic [5:0]  aw_addr;
  logic [31:0] w_data;
  logic        w_lane0;

  function automatic cmob_sel_t reg_sel(input logic [5:0] a);
    unique case (a)
      `CMOB_OFS_PAGE:     reg_sel = CMOB_SEL_PAGE;
      `CMOB_OFS_TAG1,
      `CMOB_OFS_TAG2,
      `CMOB_OFS_TAG3,
      `CMOB_OFS_TAG4:     reg_sel = CMOB_SEL_TAG;
      `CMOB_OFS_MASK1,
      `CMOB_OFS_MASK2,
      `CMOB_OFS_MASK3,
      `CMOB_OFS_MASK4:    reg_sel = CMOB_SEL_MASK;
      `CMOB_OFS_STAMP_LO: reg_sel = CMOB_SEL_STAMPL;
      `CMOB_OFS_STAMP_HI: reg_sel = CMOB_SEL_STAMPH;
      `CMOB_OFS_DATA:     reg_sel = CMOB_SEL_DATA;
      `CMOB_OFS_LAYOUT:   reg_sel = CMOB_SEL_LAYOUT;
      default:            reg_sel = CMOB_SEL_NONE;
    endcase
  endfunction

  // Byte lane of a tag or mask word: offset 1 is bits 31:24
  function automatic logic [1:0] byte_lane(input logic [5:0] a);
    byte_lane = (a >= `CMOB_OFS_MASK1) ? 2'(3 - ((a - `CMOB_OFS_MASK1) >> 2))
                                       : 2'(3 - ((a - `CMOB_OFS_TAG1) >> 2));
  endfunction

  logic        obj_ok;
  logic        ar_take;
  logic        do_write;
  cmob_sel_t   wr_sel;
  cmob_sel_t   rd_sel;
  logic        wr_win;
  logic        rd_win;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  // Object 15 is not populated
  assign obj_ok   = (object_number <= `CMOB_MAX_OBJ); // R18
  assign ar_take  = s_axi_arvalid && s_axi_arready;
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_sel   = reg_sel(aw_addr);
  assign rd_sel   = reg_sel(s_axi_araddr);
  assign wr_win   = do_write && w_lane0 && (wr_sel == CMOB_SEL_DATA) && obj_ok;
  assign rd_win   = ar_take && (rd_sel == CMOB_SEL_DATA) && obj_ok;

  // Write address and data, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_addr       <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr       <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_data       <= 32'h0000_0000;
      w_lane0      <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data       <= s_axi_wdata;
      w_lane0      <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CMOB_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == CMOB_SEL_NONE) ? `CMOB_RESP_SLVERR : `CMOB_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data, sampled at the address handshake
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = `CMOB_RESP_OKAY;
    unique case (rd_sel)
      CMOB_SEL_PAGE:
        next_rdata[7:0] = {object_number, index_autostep_disable, data_buffer_index};
      CMOB_SEL_TAG:
        if (obj_ok) next_rdata[7:0] = tag[object_number][8*byte_lane(s_axi_araddr) +: 8];
      CMOB_SEL_MASK:
        if (obj_ok) next_rdata[7:0] = mask[object_number][8*byte_lane(s_axi_araddr) +: 8];
      CMOB_SEL_STAMPL:
        if (obj_ok) next_rdata[7:0] = stamp[object_number][7:0]; // R12
      CMOB_SEL_STAMPH:
        if (obj_ok) next_rdata[7:0] = stamp[object_number][15:8]; // R12
      CMOB_SEL_DATA:
        if (obj_ok) next_rdata[7:0] = data[object_number][data_buffer_index]; // R13
      CMOB_SEL_LAYOUT:
        if (obj_ok) next_rdata[0] = layout[object_number];
      CMOB_SEL_NONE:
        next_rresp = `CMOB_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CMOB_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Page register and index stepping; a page write overrides stepping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      object_number          <= cmob_obj_t'(`CMOB_PAGE_RESET >> `CMOB_PAGE_OBJ_LSB);
      index_autostep_disable <= 1'(`CMOB_PAGE_RESET >> `CMOB_PAGE_AUTOSTEP);
      data_buffer_index      <= cmob_idx_t'(`CMOB_PAGE_RESET);
    end else if (do_write && w_lane0 && wr_sel == CMOB_SEL_PAGE) begin
      object_number          <= w_data[`CMOB_PAGE_OBJ_MSB:`CMOB_PAGE_OBJ_LSB]; // R18
      index_autostep_disable <= w_data[`CMOB_PAGE_AUTOSTEP]; // R18
      data_buffer_index      <= w_data[`CMOB_PAGE_IDX_MSB:0]; // R14
    end else if (!index_autostep_disable && (wr_win || rd_win)) begin // R17
      // A read and a write of the window in one cycle both count
      data_buffer_index <= data_buffer_index + ((wr_win && rd_win) ? 3'h2 : 3'h1); // R15 R16
    end
  end

  // Tag and layout: reception and auto reply win over software
  always_ff @(posedge aclk) begin
    if (rx_store && rx_obj <= `CMOB_MAX_OBJ) begin
      layout[rx_obj] <= rx_frame.extended;
      if (rx_frame.extended) begin
        tag[rx_obj][31:`CMOB_EXT_ID_LSB] <= rx_frame.identifier; // R3
      end else begin
        tag[rx_obj][31:`CMOB_STD_ID_LSB] <= rx_frame.identifier[`CMOB_STD_ID_W-1:0];
        tag[rx_obj][`CMOB_STD_ID_LSB-1:`CMOB_EXT_ID_LSB] <= 18'h00000;
      end
      tag[rx_obj][`CMOB_RTR_BIT] <= rx_frame.remote_request; // R1
      // Standard layout: bit 1 may take any value here
      tag[rx_obj][`CMOB_RB1_BIT] <= rx_frame.reserved1; // R4 R6
      tag[rx_obj][`CMOB_RB0_BIT] <= rx_frame.reserved0; // R4
    end else if (do_write && w_lane0 && obj_ok) begin
      if (wr_sel == CMOB_SEL_TAG) begin
        tag[object_number][8*byte_lane(aw_addr) +: 8] <= w_data[7:0]; // R20
      end
      if (wr_sel == CMOB_SEL_LAYOUT) begin
        layout[object_number] <= w_data[0];
      end
    end
    if (reply_clear && reply_obj <= `CMOB_MAX_OBJ) begin
      tag[reply_obj][`CMOB_RTR_BIT] <= 1'b0; // R2
    end
  end

  always_ff @(posedge aclk) begin
    if (do_write && w_lane0 && obj_ok && wr_sel == CMOB_SEL_MASK) begin
      mask[object_number][8*byte_lane(aw_addr) +: 8] <= w_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (rx_store && rx_obj <= `CMOB_MAX_OBJ) begin
      stamp[rx_obj] <= rx_stamp; // R12
    end
  end

  // Engine byte store takes priority over a window write
  always_ff @(posedge aclk) begin
    if (rx_data_we && rx_obj <= `CMOB_MAX_OBJ) begin
      data[rx_obj][rx_data_index] <= rx_data_byte;
    end else if (wr_win) begin
      data[object_number][data_buffer_index] <= w_data[7:0]; // R13
    end
  end

  // Frame to send, one cycle after the selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_out <= '0;
    end else if (tx_obj <= `CMOB_MAX_OBJ) begin
      tx_out.frame.extended       <= layout[tx_obj];
      tx_out.frame.identifier     <= layout[tx_obj] ? tag[tx_obj][31:`CMOB_EXT_ID_LSB] // R3
                                   : {18'h00000, tag[tx_obj][31:`CMOB_STD_ID_LSB]};
      tx_out.frame.remote_request <= tag[tx_obj][`CMOB_RTR_BIT]; // R1
      tx_out.frame.reserved1      <= layout[tx_obj] & tag[tx_obj][`CMOB_RB1_BIT]; // R4
      tx_out.frame.reserved0      <= tag[tx_obj][`CMOB_RB0_BIT]; // R4
      tx_out.data_byte            <= data[tx_obj][tx_index];
    end else begin
      tx_out <= '0;
    end
  end

  // Acceptance comparison per object
  logic [NOBJ-1:0] next_match;
  genvar g;
  generate
    for (g = 0; g < NOBJ; g++) begin : g_match
      logic id_ok;
      logic rtr_ok;
      logic ide_ok;
      // Standard compare stops at bit 21, so bit 1 never takes part
      assign id_ok  = layout[g]
        ? (((tag[g][31:`CMOB_EXT_ID_LSB] ^ accept_frame.identifier)
            & mask[g][31:`CMOB_EXT_ID_LSB]) == 29'h0) // R7
        : (((tag[g][31:`CMOB_STD_ID_LSB] ^ accept_frame.identifier[`CMOB_STD_ID_W-1:0])
            & mask[g][31:`CMOB_STD_ID_LSB]) == 11'h000); // R6 R7
      assign rtr_ok = !mask[g][`CMOB_RTR_BIT]
                      || (tag[g][`CMOB_RTR_BIT] == accept_frame.remote_request); // R8
      assign ide_ok = !mask[g][`CMOB_IDE_MASK_BIT]
                      || (layout[g] == accept_frame.extended); // R9
      assign next_match[g] = id_ok && rtr_ok && ide_ok; // R19
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accept_match <= '0;
    end else begin
      accept_match <= next_match;
    end
  end

endmodule

/* logic/cmob_defines.svh */
// Purpose: offsets, field positions and counts of the message object block
// Assumes: byte registers in the low lane of 32-bit aligned words
// Notes:   included by the package and the design
`ifndef CMOB_DEFINES_SVH
`define CMOB_DEFINES_SVH

`define CMOB_OFS_PAGE        6'h00
`define CMOB_OFS_TAG1        6'h04
`define CMOB_OFS_TAG2        6'h08
`define CMOB_OFS_TAG3        6'h0c
`define CMOB_OFS_TAG4        6'h10
`define CMOB_OFS_MASK1       6'h14
`define CMOB_OFS_MASK2       6'h18
`define CMOB_OFS_MASK3       6'h1c
`define CMOB_OFS_MASK4       6'h20
`define CMOB_OFS_STAMP_LO    6'h24
`define CMOB_OFS_STAMP_HI    6'h28
`define CMOB_OFS_DATA        6'h2c
`define CMOB_OFS_LAYOUT      6'h30

`define CMOB_NUM_OBJ         15
`define CMOB_MAX_OBJ         4'he
`define CMOB_PAGE_OBJ_MSB    7
`define CMOB_PAGE_OBJ_LSB    4
`define CMOB_PAGE_AUTOSTEP   3
`define CMOB_PAGE_IDX_MSB    2
`define CMOB_PAGE_RESET      8'h00

`define CMOB_STD_ID_LSB      21
`define CMOB_EXT_ID_LSB      3
`define CMOB_RTR_BIT         2
`define CMOB_RB1_BIT         1
`define CMOB_RB0_BIT         0
`define CMOB_IDE_MASK_BIT    0
`define CMOB_STD_ID_W        11

`define CMOB_RESP_OKAY       2'h0
`define CMOB_RESP_SLVERR     2'h2

`endif

/* logic/cmob_pkg.sv */
// Purpose: types shared by the message object block and its users
// Assumes: cmob_defines.svh on the include path
// Notes:   frame fields travel as packed structs
`include "cmob_defines.svh"
package cmob_pkg;
  typedef logic [3:0]  cmob_obj_t;
  typedef logic [2:0]  cmob_idx_t;

  typedef struct packed {
    logic [28:0] identifier;
    logic        remote_request;
    logic        reserved1;
    logic        reserved0;
    logic        extended;
  } cmob_frame_t;

  typedef struct packed {
    cmob_frame_t frame;
    logic [7:0]  data_byte;
  } cmob_tx_t;

  typedef enum logic [12:0] {
    CMOB_SEL_PAGE   = 13'h0001,
    CMOB_SEL_TAG    = 13'h0002,
    CMOB_SEL_MASK   = 13'h0004,
    CMOB_SEL_STAMPL = 13'h0008,
    CMOB_SEL_STAMPH = 13'h0010,
    CMOB_SEL_DATA   = 13'h0020,
    CMOB_SEL_LAYOUT = 13'h0040,
    CMOB_SEL_NONE   = 13'h0080
  } cmob_sel_t;
endpackage

/* bench/cmob_access_chk.sv */
// Purpose: port checks of the message object block
// Assumes: one clock, synchronous active-low reset
// Notes:   bus checks rely on the bench holding bready and rready high
`timescale 1ns/1ps
`include "cmob_defines.svh"
module cmob_access_chk (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic [5:0]         s_axi_araddr,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire cmob_pkg::cmob_obj_t tx_obj,
  input wire cmob_pkg::cmob_tx_t  tx_out,
  input wire logic               reply_clear,
  input wire cmob_pkg::cmob_obj_t reply_obj
);
  import cmob_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_reply;
    reply_clear ##1 tx_obj == $past(reply_obj);
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not released");
  a_b_readies_low: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready during response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not released");
  a_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 6'h30
    |=> s_axi_rresp == `CMOB_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_reply_clears: assert property (s_reply |=> !tx_out.frame.remote_request)
    else $error("remote tag kept after reply");
  a_obj15_idle: assert property (tx_obj == 4'hf |=> tx_out == '0)
    else $error("object 15 not idle");
  a_std_layout: assert property (!tx_out.frame.extended |->
    !tx_out.frame.reserved1 && tx_out.frame.identifier[28:11] == 18'h0)
    else $error("standard frame fields wrong");
endmodule
bind cmob_access cmob_access_chk i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_obj, .tx_out,
  .reply_clear, .reply_obj);

/* bench/cmob_access_bench.sv */
// Purpose: register-level test of the message object block
// Assumes: single-beat AXI4-Lite master, one request at a time
// Notes:   only object 1 and 2 storage is used; others stay unknown
`timescale 1ns/1ps
`include "cmob_defines.svh"
module cmob_access_bench;
  import cmob_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, reply_clear, rx_store, rx_data_we;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
  cmob_obj_t   tx_obj, reply_obj, rx_obj;
  cmob_idx_t   tx_index, rx_data_index;
  cmob_tx_t    tx_out;
  cmob_frame_t rx_frame, accept_frame;
  logic [15:0] rx_stamp;
  logic [7:0]  rx_data_byte;
  logic [14:0] accept_match;
  logic [7:0]  tg[4] = '{8'ha5, 8'h3c, 8'h96, 8'h5f};
  logic [7:0]  rt[4] = '{8'hb4, 8'h60, 8'h00, 8'h04};
  logic [7:0]  mk[4] = '{8'hff, 8'he0, 8'h00, 8'h05};
  int          failures, compares;
  cmob_access i_cmob_access (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tx_obj, .tx_index, .tx_out, .reply_clear, .reply_obj,
    .rx_store, .rx_obj, .rx_frame, .rx_stamp, .rx_data_we, .rx_data_index, .rx_data_byte,
    .accept_frame, .accept_match);
  task automatic complete_run;
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: response %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic give_up;
    failures++;
    $display("unexpected at %0t: no answer", $time);
    complete_run;
  endtask
  // Holds each channel until its own ready; both are offered together and taken in the same cycle
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 20) give_up;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk_resp(s_axi_bresp, `CMOB_RESP_OKAY);
  endtask
  task automatic rd(input logic [5:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 20) give_up;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    rd(a);
    chk_data(rd_data, {24'h0, e});
    chk_resp(rd_resp, `CMOB_RESP_OKAY);
  endtask
  // Outputs are registered; two edges let them catch up
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask
  task automatic chk_match(input cmob_frame_t f, input logic e);
    @(posedge aclk);
    accept_frame <= f;
    settle;
    chk_data({31'h0, accept_match[2]}, {31'h0, e});
  endtask
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_obj, tx_index, reply_obj, rx_obj} = '0;
    {reply_clear, rx_store, rx_data_we, rx_data_index, rx_data_byte, rx_stamp} = '0;
    rx_frame = '0;
    accept_frame = '0;
    s_axi_wstrb = 4'h1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wr(`CMOB_OFS_PAGE, 8'h10);
    for (int i = 0; i < 9; i++) wr(`CMOB_OFS_DATA, 8'h10 + i[7:0]);
    wr(`CMOB_OFS_PAGE, 8'h10);
    for (int i = 0; i < 9; i++) rdc(`CMOB_OFS_DATA, i % 8 == 0 ? 8'h18 : 8'h10 + i[7:0]);
    wr(`CMOB_OFS_PAGE, 8'h13);
    rdc(`CMOB_OFS_DATA, 8'h13);
    wr(`CMOB_OFS_PAGE, 8'h1d);
    repeat (2) rdc(`CMOB_OFS_DATA, 8'h15);
    rdc(`CMOB_OFS_PAGE, 8'h1d);
    wr(`CMOB_OFS_LAYOUT, 8'h01);
    rdc(`CMOB_OFS_LAYOUT, 8'h01);
    for (int i = 0; i < 4; i++) wr(`CMOB_OFS_TAG1 + 6'(4 * i), tg[i]);
    tx_obj <= 4'h1;
    settle;
    chk_data({3'h0, tx_out.frame.identifier}, 32'h14a792cb);
    chk_data({28'h0, tx_out.frame[3:0]}, 32'hf);
    chk_data({24'h0, tx_out.data_byte}, 32'h18);
    @(posedge aclk);
    reply_obj <= 4'h1;
    reply_clear <= 1'b1;
    @(posedge aclk);
    reply_clear <= 1'b0;
    settle;
    chk_data({31'h0, tx_out.frame.remote_request}, 32'h0);
    rdc(`CMOB_OFS_TAG4, 8'h5b);
    // Frame, stamp and a data byte arrive together in object 2
    rx_frame <= {29'h5a3, 4'b1000};
    {rx_obj, rx_stamp, rx_data_index, rx_data_byte} <= {4'h2, 16'hbeef, 3'h3, 8'h77};
    {rx_store, rx_data_we} <= 2'b11;
    @(posedge aclk);
    {rx_store, rx_data_we} <= 2'b00;
    wr(`CMOB_OFS_PAGE, 8'h23);
    rdc(`CMOB_OFS_DATA, 8'h77);
    for (int i = 0; i < 4; i++) rdc(`CMOB_OFS_TAG1 + 6'(4 * i), rt[i]);
    rdc(`CMOB_OFS_STAMP_LO, 8'hef);
    wr(`CMOB_OFS_STAMP_LO, 8'h00);
    rdc(`CMOB_OFS_STAMP_LO, 8'hef);
    rdc(`CMOB_OFS_STAMP_HI, 8'hbe);
    wr(`CMOB_OFS_PAGE, 8'h10);
    rdc(`CMOB_OFS_TAG1, 8'ha5);
    wr(`CMOB_OFS_PAGE, 8'h20);
    for (int i = 0; i < 4; i++) wr(`CMOB_OFS_MASK1 + 6'(4 * i), mk[i]);
    chk_match({29'h5a3, 4'b1000}, 1'b1);
    chk_match({29'h5a2, 4'b1000}, 1'b0);
    chk_match({29'h5a3, 4'b0000}, 1'b0);
    chk_match({29'h5a3, 4'b1100}, 1'b1);
    chk_match({29'h5a3, 4'b1001}, 1'b0);
    wr(`CMOB_OFS_MASK2, 8'hc0);
    wr(`CMOB_OFS_MASK4, 8'h00);
    chk_match({29'h5a2, 4'b0000}, 1'b1);
    wr(`CMOB_OFS_TAG4, 8'h01);
    rdc(`CMOB_OFS_TAG4, 8'h01);
    wr(`CMOB_OFS_PAGE, 8'h10);
    wr(`CMOB_OFS_MASK4, 8'h05);
    rdc(`CMOB_OFS_MASK4, 8'h05);
    wr(`CMOB_OFS_PAGE, 8'hf0);
    wr(`CMOB_OFS_TAG1, 8'h55);
    rdc(`CMOB_OFS_TAG1, 8'h00);
    tx_obj <= 4'hf;
    settle;
    chk_data(32'(tx_out), 32'h0);
    chk_data({23'h0, tx_out[40:32]}, 32'h0);
    rd(6'h34);
    chk_data(rd_data, 32'h0);
    chk_resp(rd_resp, `CMOB_RESP_SLVERR);
    complete_run;
  end
endmodule
